// ===== verilog/rflc_cfg.svh
// command codes, reset values, field positions and timing of the fault-limit command set
`ifndef RFLC_CFG_SVH
`define RFLC_CFG_SVH
// ===================================
// command codes
`define RFLC_CMD_UV_LIM 8'h44
`define RFLC_CMD_UV_RSP 8'h45
`define RFLC_CMD_OC_LIM 8'h46
`define RFLC_CMD_OC_RSP 8'h47
`define RFLC_CMD_OCW_LIM 8'h4A
`define RFLC_CMD_OT_LIM 8'h4F
`define RFLC_CMD_OT_RSP 8'h50
`define RFLC_CMD_OTW_LIM 8'h51
`define RFLC_CMD_VOV_LIM 8'h55
`define RFLC_CMD_VOV_RSP 8'h56
`define RFLC_CMD_VUVW_LIM 8'h58
`define RFLC_CMD_PG_ON 8'h5E
`define RFLC_CMD_PG_OFF 8'h5F
`define RFLC_CMD_TON_DLY 8'h60
`define RFLC_CMD_STARTUP_RAMP_TIME 8'h61
`define RFLC_CMD_TON_MAX 8'h62
`define RFLC_CMD_TON_RSP 8'h63
`define RFLC_CMD_TOFF_DLY 8'h64
`define RFLC_CMD_SHUTDOWN_FALL_TIME 8'h65
`define RFLC_CMD_STATUS 8'h78
// ===================================
// reset values (linear16 in 1/256 V, linear11 with fixed exponent)
`define RFLC_RST_UV_LIM 16'h0065
`define RFLC_RST_UV_RSP 16'h0000
`define RFLC_RST_OC_LIM 16'hF842
`define RFLC_RST_OC_RSP 16'h007F
`define RFLC_RST_OCW_LIM 16'hF838
`define RFLC_RST_OT_LIM 16'h0091
`define RFLC_RST_OT_RSP 16'h00C0
`define RFLC_RST_OTW_LIM 16'h007D
`define RFLC_RST_VOV_LIM 16'hF060
`define RFLC_RST_VOV_RSP 16'h0080
`define RFLC_RST_VUVW_LIM 16'hF801
`define RFLC_RST_PG_ON 16'h0073
`define RFLC_RST_PG_OFF 16'h006B
`define RFLC_RST_TON_DLY 16'h0000
`define RFLC_RST_STARTUP_RAMP_TIME 16'h0002
`define RFLC_RST_TON_MAX 16'h0000
`define RFLC_RST_TON_RSP 16'h0000
`define RFLC_RST_TOFF_DLY 16'h0000
`define RFLC_RST_SHUTDOWN_FALL_TIME 16'h0001
// ===================================
// linear11 exponents and mantissa ranges
`define RFLC_EXP_Z 5'h00
`define RFLC_EXP_M1 5'h1F
`define RFLC_EXP_M2 5'h1E
`define RFLC_OC_MIN 11'h006
`define RFLC_OC_MAX 11'h04B
`define RFLC_OCW_MAX 11'h07F
`define RFLC_OT_MAX 11'h096
`define RFLC_VOV_MIN 11'h019
`define RFLC_VOV_MAX 11'h060
`define RFLC_VUVW_MAX 11'h020
`define RFLC_TON_MAX 11'h07F
`define RFLC_RISE_MIN 11'h001
// ===================================
// response byte fields and modes
`define RFLC_MODE_IGNORE 2'h0
`define RFLC_MODE_LIMIT 2'h1
`define RFLC_MODE_SHUT 2'h2
`define RFLC_MODE_INHIBIT 2'h3
// ===================================
// timing
`define RFLC_CLK_PERIOD_NS 20
`define RFLC_MS_NS 1000000
`endif

// ===== verilog/rflc_pkg.sv
// types shared by the fault-limit command block
`default_nettype none
package rflc_pkg;
   // register slots, in command-code order
   typedef enum {IX_UV_LIM, IX_UV_RSP, IX_OC_LIM, IX_OC_RSP, IX_OCW_LIM, IX_OT_LIM, IX_OT_RSP,
      IX_OTW_LIM, IX_VOV_LIM, IX_VOV_RSP, IX_VUVW_LIM, IX_PG_ON, IX_PG_OFF, IX_TON_DLY,
      IX_STARTUP_RAMP_TIME, IX_TON_MAX, IX_TON_RSP, IX_TOFF_DLY, IX_SHUTDOWN_FALL_TIME, IX_COUNT} rflc_ix_t;
   typedef enum {SEQ_OFF, SEQ_DELAY, SEQ_RISE, SEQ_ON, SEQ_HOLD} rflc_seq_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] code;
      logic [15:0] data;
   } rflc_cmd_t;
   typedef struct packed {
      logic ack;
      logic nak;
      logic [15:0] data;
   } rflc_rsp_t;
   typedef struct packed {
      logic [15:0] vout;
      logic [10:0] iout;
      logic [10:0] temp;
      logic [10:0] vin;
   } rflc_sense_t;
   typedef struct packed {
      logic uv_fault;
      logic oc_fault;
      logic oc_warn;
      logic ot_fault;
      logic ot_warn;
      logic vin_ov_fault;
      logic vin_uv_warn;
      logic ton_max_fault;
   } rflc_mon_t;
endpackage
`default_nettype wire

// ===== verilog/rflc_regs.sv
// fault-limit, start-up timing and summary status command block of a buck regulator
//
// Contract
// RULE1 - undervoltage fault when output below limit; 1/256 V steps, reset about 0.395 V
// RULE2 - undervoltage reaction ignores or shuts down; ignore after reset
// RULE3 - overcurrent fault at limit; 3-37.5 A, half amp steps, 33 A, exponent -1
// RULE4 - overcurrent warning at 0-63.5 A threshold, half amp steps, 28 A
// RULE5 - overtemperature fault at 0-150 C, one degree steps, 145 C, exponent 0
// RULE6 - overtemperature reaction ignores, shuts down or inhibits; inhibit after reset
// RULE7 - overtemperature warning at own threshold, one degree steps, 125 C
// RULE8 - input overvoltage fault at 6.25-24 V, quarter volt steps, 24 V, exponent -2
// RULE9 - input overvoltage reaction ignores or shuts down; shutdown after reset
// RULE10 - input warning threshold 0-16 V in half volt steps, 0.5 V, exponent -1
// RULE11 - power good asserts at on threshold, scaled by loop factor, 0.45 V
// RULE12 - power good negates at off threshold, scaled likewise, 0.42 V
// RULE13 - wait programmed 0-127 ms delay after start before rising; 0 ms default
// RULE14 - ramp output over programmed 1-127 ms rise time; 2 ms default
// RULE15 - start-up timeout fault if undervoltage limit not reached in time; 0 disables
// RULE16 - start-up timeout reaction ignores or shuts down; ignore after reset
// RULE17 - fall-time command is acknowledged and its value has no effect
// RULE18 - status byte bit 7 reports device busy
// RULE19 - status byte bit 6 set whenever the output is off
// RULE20 - overcurrent default: limit pulse by pulse eight cycles, then hiccup or latch
`timescale 1ns/1ps
`default_nettype none
`include "rflc_cfg.svh"
module rflc_regs import rflc_pkg::*; #(
   parameter int MS_CYCLES = `RFLC_MS_NS / `RFLC_CLK_PERIOD_NS
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire rflc_cmd_t cmd,
   output var rflc_rsp_t rsp,
   input wire rflc_sense_t sense,
   input wire logic [1:0] scale_shift,
   input wire logic sw_cycle,
   input wire logic enable_pin,
   input wire logic clear_faults,
   output var rflc_mon_t mon,
   output var logic [7:0] status,
   output logic power_good,
   output logic out_enable,
   output logic ramp_active,
   output logic pulse_limit
);
   localparam int NREG = IX_COUNT;
   localparam int DIVW = $clog2(MS_CYCLES);

   // ===================================
   // decoding helpers
   function automatic int code_ix(input logic [7:0] c);
      case (c)
         `RFLC_CMD_UV_LIM: return IX_UV_LIM;
         `RFLC_CMD_UV_RSP: return IX_UV_RSP;
         `RFLC_CMD_OC_LIM: return IX_OC_LIM;
         `RFLC_CMD_OC_RSP: return IX_OC_RSP;
         `RFLC_CMD_OCW_LIM: return IX_OCW_LIM;
         `RFLC_CMD_OT_LIM: return IX_OT_LIM;
         `RFLC_CMD_OT_RSP: return IX_OT_RSP;
         `RFLC_CMD_OTW_LIM: return IX_OTW_LIM;
         `RFLC_CMD_VOV_LIM: return IX_VOV_LIM;
         `RFLC_CMD_VOV_RSP: return IX_VOV_RSP;
         `RFLC_CMD_VUVW_LIM: return IX_VUVW_LIM;
         `RFLC_CMD_PG_ON: return IX_PG_ON;
         `RFLC_CMD_PG_OFF: return IX_PG_OFF;
         `RFLC_CMD_TON_DLY: return IX_TON_DLY;
         `RFLC_CMD_STARTUP_RAMP_TIME: return IX_STARTUP_RAMP_TIME;
         `RFLC_CMD_TON_MAX: return IX_TON_MAX;
         `RFLC_CMD_TON_RSP: return IX_TON_RSP;
         `RFLC_CMD_TOFF_DLY: return IX_TOFF_DLY;
         `RFLC_CMD_SHUTDOWN_FALL_TIME: return IX_SHUTDOWN_FALL_TIME;
         default: return -1;
      endcase
   endfunction

   function automatic logic [15:0] rst_val(input int ix);
      case (ix)
         IX_UV_LIM: return `RFLC_RST_UV_LIM;
         IX_UV_RSP: return `RFLC_RST_UV_RSP;
         IX_OC_LIM: return `RFLC_RST_OC_LIM;
         IX_OC_RSP: return `RFLC_RST_OC_RSP;
         IX_OCW_LIM: return `RFLC_RST_OCW_LIM;
         IX_OT_LIM: return `RFLC_RST_OT_LIM;
         IX_OT_RSP: return `RFLC_RST_OT_RSP;
         IX_OTW_LIM: return `RFLC_RST_OTW_LIM;
         IX_VOV_LIM: return `RFLC_RST_VOV_LIM;
         IX_VOV_RSP: return `RFLC_RST_VOV_RSP;
         IX_VUVW_LIM: return `RFLC_RST_VUVW_LIM;
         IX_PG_ON: return `RFLC_RST_PG_ON;
         IX_PG_OFF: return `RFLC_RST_PG_OFF;
         IX_TON_DLY: return `RFLC_RST_TON_DLY;
         IX_STARTUP_RAMP_TIME: return `RFLC_RST_STARTUP_RAMP_TIME;
         IX_TON_MAX: return `RFLC_RST_TON_MAX;
         IX_TON_RSP: return `RFLC_RST_TON_RSP;
         IX_TOFF_DLY: return `RFLC_RST_TOFF_DLY;
         default: return `RFLC_RST_SHUTDOWN_FALL_TIME;
      endcase
   endfunction

   // linear11 word with the one allowed exponent and a mantissa inside the range
   function automatic logic lin_ok(input logic [15:0] d, input logic [4:0] e,
                                   input logic [10:0] lo, input logic [10:0] hi);
      return (d[15:11] == e) && (d[10:0] >= lo) && (d[10:0] <= hi);
   endfunction

   function automatic logic wr_ok(input int ix, input logic [15:0] d);
      case (ix)
         IX_OC_LIM: return lin_ok(d, `RFLC_EXP_M1, `RFLC_OC_MIN, `RFLC_OC_MAX); // [RULE3]
         IX_OCW_LIM: return lin_ok(d, `RFLC_EXP_M1, 11'h000, `RFLC_OCW_MAX); // [RULE4]
         IX_OT_LIM: return lin_ok(d, `RFLC_EXP_Z, 11'h000, `RFLC_OT_MAX); // [RULE5]
         IX_OTW_LIM: return lin_ok(d, `RFLC_EXP_Z, 11'h000, `RFLC_OT_MAX); // [RULE7]
         IX_VOV_LIM: return lin_ok(d, `RFLC_EXP_M2, `RFLC_VOV_MIN, `RFLC_VOV_MAX); // [RULE8]
         IX_VUVW_LIM: return lin_ok(d, `RFLC_EXP_M1, 11'h000, `RFLC_VUVW_MAX); // [RULE10]
         IX_TON_DLY: return lin_ok(d, `RFLC_EXP_Z, 11'h000, `RFLC_TON_MAX); // [RULE13]
         IX_STARTUP_RAMP_TIME: return lin_ok(d, `RFLC_EXP_Z, `RFLC_RISE_MIN, `RFLC_TON_MAX); // [RULE14]
         IX_TON_MAX: return lin_ok(d, `RFLC_EXP_Z, 11'h000, `RFLC_TON_MAX); // [RULE15]
         IX_TOFF_DLY: return lin_ok(d, `RFLC_EXP_Z, 11'h000, `RFLC_TON_MAX);
         IX_SHUTDOWN_FALL_TIME: return 1'b1; // [RULE17]
         default: return ix >= 0;
      endcase
   endfunction

   function automatic logic is_byte(input int ix);
      return ix == IX_UV_RSP || ix == IX_OC_RSP || ix == IX_OT_RSP || ix == IX_VOV_RSP
         || ix == IX_TON_RSP;
   endfunction

   // shutdown-type reactions; inhibit counts as shutdown where it is not offered
   function automatic logic shuts(input logic [15:0] r);
      return r[7];
   endfunction

   // ===================================
   // command port decode
   logic [15:0] reg_q [NREG];
   rflc_seq_t seq_q, seq_d;
   int cmd_ix;
   logic is_status, timing_cmd, busy_refuse, wr_accept, nak_d, any_cmd;
   logic [15:0] wdata_m, rd_data;
   logic busy_q, cml_q, oc_q, ot_q, other_q, running;

   assign cmd_ix = code_ix(cmd.code);
   assign any_cmd = cmd.wr || cmd.rd;
   assign is_status = cmd.code == `RFLC_CMD_STATUS;
   assign running = seq_q == SEQ_RISE || seq_q == SEQ_ON;
   // timing is not rewritten under a running start-up, it would tear the sequence
   assign timing_cmd = cmd_ix == IX_TON_DLY || cmd_ix == IX_STARTUP_RAMP_TIME || cmd_ix == IX_TON_MAX;
   assign busy_refuse = cmd.wr && timing_cmd && (seq_q == SEQ_DELAY || seq_q == SEQ_RISE);
   assign wr_accept = cmd.wr && wr_ok(cmd_ix, cmd.data) && !busy_refuse;
   assign nak_d = (cmd.wr && !wr_accept) || (cmd.rd && cmd_ix < 0 && !is_status);
   assign wdata_m = is_byte(cmd_ix) ? {8'h00, cmd.data[7:0]} : cmd.data;
   assign rd_data = is_status ? {8'h00, status} : (cmd_ix >= 0 ? reg_q[cmd_ix] : 16'h0000);

   // one flop word per command; byte commands keep the upper byte at zero
   for (genvar i = 0; i < NREG; i++) begin : g_reg
      always_ff @(posedge ref_clk) begin
         if (reset) begin
            reg_q[i] <= rst_val(i);
         end else if (wr_accept && cmd_ix == i) begin
            reg_q[i] <= wdata_m;
         end
      end
   end

   // answer one cycle after the request
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rsp <= '0;
      end else begin
         rsp.ack <= any_cmd;
         rsp.nak <= any_cmd && nak_d;
         rsp.data <= (cmd.rd && !nak_d) ? rd_data : rsp.data;
      end
   end

   // ===================================
   // threshold compare against sensed values
   logic uv_below, oc_now, ocw_now, ot_now, otw_now, vov_now, vuv_now;
   logic [15:0] pg_on_th, pg_off_th;
   logic [1:0] oc_mode, ot_mode;

   assign uv_below = sense.vout < reg_q[IX_UV_LIM]; // [RULE1]
   assign oc_now = sense.iout >= reg_q[IX_OC_LIM][10:0]; // [RULE3]
   assign ocw_now = sense.iout >= reg_q[IX_OCW_LIM][10:0]; // [RULE4]
   assign ot_now = sense.temp >= reg_q[IX_OT_LIM][10:0]; // [RULE5]
   assign otw_now = sense.temp >= reg_q[IX_OTW_LIM][10:0]; // [RULE7]
   // input sense is in quarter volts, so the half-volt warning mantissa doubles
   assign vov_now = sense.vin >= reg_q[IX_VOV_LIM][10:0]; // [RULE8]
   assign vuv_now = sense.vin < {reg_q[IX_VUVW_LIM][9:0], 1'b0}; // [RULE10]
   // thresholds are programmed at the output, the sense pin sees them divided
   assign pg_on_th = reg_q[IX_PG_ON] >> scale_shift; // [RULE11]
   assign pg_off_th = reg_q[IX_PG_OFF] >> scale_shift; // [RULE12]
   assign oc_mode = reg_q[IX_OC_RSP][7:6];
   assign ot_mode = reg_q[IX_OT_RSP][7:6];

   // ===================================
   // enable pin synchroniser and millisecond tick
   logic en_meta_q, en_s_q, ms_tick;
   logic [DIVW-1:0] div_q;
   logic [7:0] elapsed_q;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         en_meta_q <= 1'b0;
         en_s_q <= 1'b0;
      end else begin
         en_meta_q <= enable_pin;
         en_s_q <= en_meta_q;
      end
   end

   assign ms_tick = div_q == DIVW'(MS_CYCLES - 1);

   always_ff @(posedge ref_clk) begin
      if (reset || ms_tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   // ===================================
   // fault reactions
   logic uv_evt, tonmax_evt, reached_q, tonmax_q, oc_trip, hiccup, shut, inhibit;
   logic [3:0] oc_cnt_q;

   assign uv_evt = seq_q == SEQ_ON && uv_below; // [RULE1]
   // the output counts as reached once it first clears the undervoltage limit
   assign tonmax_evt = running && !reached_q && !tonmax_q && reg_q[IX_TON_MAX][7:0] != 8'h00
      && elapsed_q >= reg_q[IX_TON_MAX][7:0]; // [RULE15]
   // trip once the limit has held through delay-field-plus-one switching cycles
   assign oc_trip = running && oc_mode == `RFLC_MODE_LIMIT && sw_cycle && oc_now
      && oc_cnt_q == {1'b0, reg_q[IX_OC_RSP][2:0]}; // [RULE20]
   assign hiccup = oc_trip && reg_q[IX_OC_RSP][5:3] != 3'h0; // [RULE20]
   assign inhibit = ot_now && ot_mode == `RFLC_MODE_INHIBIT; // [RULE6]
   assign shut = seq_q != SEQ_OFF && (
      (uv_evt && shuts(reg_q[IX_UV_RSP])) // [RULE2]
      || (vov_now && shuts(reg_q[IX_VOV_RSP])) // [RULE9]
      || (ot_now && ot_mode == `RFLC_MODE_SHUT) // [RULE6]
      || (tonmax_evt && shuts(reg_q[IX_TON_RSP])) // [RULE16]
      || (oc_trip && !hiccup) // [RULE20]
      || (running && oc_now && oc_mode[1])); // [RULE3]

   // consecutive switching cycles spent in current limit
   always_ff @(posedge ref_clk) begin
      if (reset || !running) begin
         oc_cnt_q <= 4'h0;
      end else if (sw_cycle) begin
         oc_cnt_q <= (oc_now && !oc_trip) ? oc_cnt_q + 4'h1 : 4'h0;
      end
   end

   // ===================================
   // start-up sequencer
   always_comb begin
      seq_d = seq_q;
      unique case (seq_q)
         SEQ_OFF: if (en_s_q && !inhibit) seq_d = SEQ_DELAY;
         SEQ_DELAY: if (elapsed_q >= reg_q[IX_TON_DLY][7:0]) seq_d = SEQ_RISE; // [RULE13]
         SEQ_RISE: if (elapsed_q >= reg_q[IX_STARTUP_RAMP_TIME][7:0]) seq_d = SEQ_ON; // [RULE14]
         SEQ_ON: seq_d = SEQ_ON;
         SEQ_HOLD: seq_d = SEQ_HOLD;
      endcase
      if (hiccup) seq_d = SEQ_DELAY;
      if (shut) seq_d = SEQ_HOLD;
      if (inhibit && seq_q != SEQ_HOLD) seq_d = SEQ_OFF; // [RULE6]
      if (!en_s_q) seq_d = SEQ_OFF;
   end

   // elapsed time carries from rise into regulation so the timeout spans both
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         seq_q <= SEQ_OFF;
         elapsed_q <= 8'h00;
      end else begin
         seq_q <= seq_d;
         if (seq_d != seq_q && !(seq_q == SEQ_RISE && seq_d == SEQ_ON)) begin
            elapsed_q <= 8'h00;
         end else if (ms_tick && elapsed_q != 8'hFF) begin
            elapsed_q <= elapsed_q + 8'h01;
         end
      end
   end

   // timeout bookkeeping, restarted with every new attempt
   always_ff @(posedge ref_clk) begin
      if (reset || !running) begin
         reached_q <= 1'b0;
         tonmax_q <= 1'b0;
      end else begin
         reached_q <= reached_q || !uv_below; // [RULE15]
         tonmax_q <= tonmax_q || tonmax_evt;
      end
   end

   // ===================================
   // power good with hysteresis, forced low while the output is off
   always_ff @(posedge ref_clk) begin
      if (reset || !running) begin
         power_good <= 1'b0;
      end else if (sense.vout >= pg_on_th) begin
         power_good <= 1'b1; // [RULE11]
      end else if (sense.vout <= pg_off_th) begin
         power_good <= 1'b0; // [RULE12]
      end
   end

   // ===================================
   // monitor outputs and sticky status; a set in the clear cycle wins
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         mon <= '0;
         pulse_limit <= 1'b0;
         busy_q <= 1'b0;
         cml_q <= 1'b0;
         oc_q <= 1'b0;
         ot_q <= 1'b0;
         other_q <= 1'b0;
      end else begin
         mon <= '{uv_fault: uv_evt, oc_fault: oc_now, oc_warn: ocw_now, ot_fault: ot_now,
            ot_warn: otw_now, vin_ov_fault: vov_now, vin_uv_warn: vuv_now,
            ton_max_fault: tonmax_q};
         pulse_limit <= running && oc_now && oc_mode == `RFLC_MODE_LIMIT; // [RULE20]
         busy_q <= busy_refuse || (busy_q && !clear_faults); // [RULE18]
         cml_q <= (any_cmd && nak_d && !busy_refuse) || (cml_q && !clear_faults);
         oc_q <= (running && oc_now) || (oc_q && !clear_faults);
         ot_q <= ot_now || (ot_q && !clear_faults);
         other_q <= uv_evt || tonmax_evt || vov_now || (other_q && !clear_faults);
      end
   end

   // summary byte: busy, off, overvoltage(0), overcurrent, input uv(0), temp, comms, other
   assign status = {busy_q, !running, 1'b0, oc_q, 1'b0, ot_q, cml_q, other_q}; // [RULE18] [RULE19]
   assign out_enable = running;
   assign ramp_active = seq_q == SEQ_RISE; // [RULE14]

   // ===================================
   // checks
   pg_off_low_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE12]
      !running |=> !power_good) else $error("power good high with output off");
   pg_on_rise_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE11]
      running && seq_d != SEQ_OFF && seq_d != SEQ_HOLD && sense.vout >= pg_on_th
      |=> power_good) else $error("power good missed on threshold");
   uv_shutdown_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE2]
      seq_q == SEQ_ON && uv_below && reg_q[IX_UV_RSP][7] && en_s_q && !inhibit
      |=> seq_q == SEQ_HOLD) else $error("undervoltage shutdown not taken");
   ot_inhibit_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE6]
      ot_now && ot_mode == `RFLC_MODE_INHIBIT && seq_q == SEQ_ON |=> seq_q == SEQ_OFF)
      else $error("overtemperature inhibit not taken");
   vin_ov_shut_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE9]
      seq_q == SEQ_ON && vov_now && reg_q[IX_VOV_RSP][7] && en_s_q && !inhibit
      |=> seq_q == SEQ_HOLD) else $error("input overvoltage shutdown not taken");
   delay_hold_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE13]
      seq_q == SEQ_DELAY && elapsed_q < reg_q[IX_TON_DLY][7:0] |=> seq_q != SEQ_RISE)
      else $error("rise began before delay expired");
   fall_ack_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE17]
      cmd.wr && cmd.code == `RFLC_CMD_SHUTDOWN_FALL_TIME |=> rsp.ack && !rsp.nak)
      else $error("fall-time write not acknowledged");
   busy_flag_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE18]
      busy_refuse |=> status[7] && rsp.nak) else $error("busy not reported");
   off_bit_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE19]
      (!en_s_q || shut) |=> status[6]) else $error("off bit not set with output stopped");
   oc_latch_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE20]
      oc_trip && reg_q[IX_OC_RSP][5:3] == 3'h0 && en_s_q && !inhibit |=> seq_q == SEQ_HOLD)
      else $error("overcurrent latch-off not taken");
   ton_max_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE15]
      tonmax_evt && running && seq_d == seq_q |=> mon.ton_max_fault == 1'b0 ##1 mon.ton_max_fault)
      else $error("start-up timeout not flagged");
endmodule // rflc_regs
`default_nettype wire

// ===== sim/rflc_host.sv
// host controller model that issues single commands to the regulator command port
`timescale 1ns/1ps
`default_nettype none
module rflc_host import rflc_pkg::*; (
   input wire logic ref_clk,
   output var rflc_cmd_t cmd
);
   // ==========================================
   // request pulse
   // one-cycle request; released fields show the inverse so stale values never pass for live ones
   task automatic xfer(input logic rd, input logic [7:0] code, input logic [15:0] data);
      @(negedge ref_clk);
      cmd = '{wr: !rd, rd: rd, code: code, data: data};
      @(negedge ref_clk);
      cmd = '{wr: 1'b0, rd: 1'b0, code: ~code, data: ~data};
   endtask
   initial cmd = '0;
endmodule // rflc_host
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench of the fault-limit command block
`timescale 1ns/1ps
`default_nettype none
`include "rflc_cfg.svh"
module tb import rflc_pkg::*; ;
   logic ref_clk = 1'b0, reset = 1'b1, enable_pin = 1'b0, sw_cycle = 1'b0, clear_faults = 1'b0;
   logic [15:0] vout = 16'h0080;
   logic [10:0] iout = 11'h000, temp = 11'h019, vin = 11'h040, oc_load = 11'h000;
   logic [1:0] scale_shift = 2'h0;
   integer seed = 3686, fail_count = 0, total_checks = 0, n;
   logic [17:0] exp_q[$];
   logic [17:0] e;
   rflc_cmd_t cmd;
   rflc_rsp_t rsp;
   rflc_mon_t mon;
   logic [7:0] status;
   logic power_good, out_enable, ramp_active, pulse_limit;
   wire rflc_sense_t sense = {vout, iout, temp, vin};
   // ==========================================
   // clock, design and host
   initial forever #10 ref_clk = ~ref_clk;
   rflc_regs #(.MS_CYCLES(10)) i_dut (.ref_clk(ref_clk), .reset(reset), .cmd(cmd), .rsp(rsp),
      .sense(sense), .scale_shift(scale_shift), .sw_cycle(sw_cycle), .enable_pin(enable_pin),
      .clear_faults(clear_faults), .mon(mon), .status(status), .power_good(power_good),
      .out_enable(out_enable), .ramp_active(ramp_active), .pulse_limit(pulse_limit));
   rflc_host i_host (.ref_clk(ref_clk), .cmd(cmd));
   // ==========================================
   // tasks
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask
   // expectation noted as {read, refused, data} before the request goes out
   task automatic rd(input logic [7:0] code, input logic [15:0] exp);
      exp_q.push_back({2'b10, exp});
      i_host.xfer(1'b1, code, 16'h0000);
   endtask
   task automatic wr(input logic [7:0] code, input logic [15:0] data, input logic nak);
      exp_q.push_back({1'b0, nak, 16'h0000});
      i_host.xfer(1'b0, code, data);
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ==========================================
   // answer watcher: ack is settled by the falling edge, so it is sampled there
   always @(negedge ref_clk) if (rsp.ack === 1'b1) begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : 18'h3FFFF;
      check(rsp.nak, e[16]);
      if (e[17]) check(rsp.data, e[15:0]);
   end
   // random load below warning levels and input supply between its undervoltage warning and overvoltage fault levels, unless oc_load lifts the load on purpose
   always @(negedge ref_clk) begin
      iout <= oc_load | (11'($random(seed)) & 11'h01F);
      vin <= 11'h030 + (11'($random(seed)) & 11'h01F);
      sw_cycle <= 1'($random(seed));
   end
   initial begin
      #500us;
      fail_count++;
      print_verdict;
   end
   // ==========================================
   // main sequence
   initial begin
      repeat (16) @(negedge ref_clk);
      reset = 1'b0;
      rd(`RFLC_CMD_UV_LIM, `RFLC_RST_UV_LIM);
      rd(`RFLC_CMD_UV_RSP, `RFLC_RST_UV_RSP);
      rd(`RFLC_CMD_OC_LIM, `RFLC_RST_OC_LIM);
      rd(`RFLC_CMD_OCW_LIM, `RFLC_RST_OCW_LIM);
      rd(`RFLC_CMD_OT_LIM, `RFLC_RST_OT_LIM);
      rd(`RFLC_CMD_OT_RSP, `RFLC_RST_OT_RSP);
      rd(`RFLC_CMD_OTW_LIM, `RFLC_RST_OTW_LIM);
      rd(`RFLC_CMD_VOV_LIM, `RFLC_RST_VOV_LIM);
      rd(`RFLC_CMD_VOV_RSP, `RFLC_RST_VOV_RSP);
      rd(`RFLC_CMD_VUVW_LIM, `RFLC_RST_VUVW_LIM);
      rd(`RFLC_CMD_PG_ON, `RFLC_RST_PG_ON);
      rd(`RFLC_CMD_PG_OFF, `RFLC_RST_PG_OFF);
      rd(`RFLC_CMD_TON_DLY, `RFLC_RST_TON_DLY);
      rd(`RFLC_CMD_STARTUP_RAMP_TIME, `RFLC_RST_STARTUP_RAMP_TIME);
      rd(`RFLC_CMD_TON_MAX, `RFLC_RST_TON_MAX);
      rd(`RFLC_CMD_TON_RSP, `RFLC_RST_TON_RSP);
      rd(`RFLC_CMD_OC_RSP, `RFLC_RST_OC_RSP);
      rd(`RFLC_CMD_STATUS, 16'h0040);
      // limit boundaries and refusals leave the stored value alone
      wr(`RFLC_CMD_OC_LIM, 16'hF806, 1'b0);
      wr(`RFLC_CMD_OC_LIM, 16'hF84C, 1'b1);
      wr(`RFLC_CMD_OC_LIM, 16'hF04B, 1'b1);
      rd(`RFLC_CMD_OC_LIM, 16'hF806);
      wr(`RFLC_CMD_OC_LIM, `RFLC_RST_OC_LIM, 1'b0);
      wr(`RFLC_CMD_OT_LIM, 16'h0097, 1'b1);
      wr(`RFLC_CMD_VOV_LIM, 16'hF018, 1'b1);
      wr(`RFLC_CMD_STARTUP_RAMP_TIME, 16'h0000, 1'b1);
      wr(`RFLC_CMD_SHUTDOWN_FALL_TIME, 16'h0005, 1'b0);
      rd(`RFLC_CMD_SHUTDOWN_FALL_TIME, 16'h0005);
      wr(`RFLC_CMD_STATUS, 16'h0000, 1'b1);
      // overtemperature inhibit holds the output off while enabled
      temp = 11'h0A0;
      enable_pin = 1'b1;
      repeat (20) @(negedge ref_clk);
      check(mon.ot_fault, 1'b1);
      check(mon.ot_warn, 1'b1);
      check(out_enable, 1'b0);
      check(status[6], 1'b1);
      temp = 11'h019;
      for (n = 0; n < 20 && ramp_active !== 1'b1; n++) @(negedge ref_clk);
      check(ramp_active, 1'b1);
      wr(`RFLC_CMD_TON_DLY, 16'h0005, 1'b1);
      check(status[7], 1'b1);
      for (n = 0; n < 40 && ramp_active === 1'b1; n++) @(negedge ref_clk);
      check(out_enable, 1'b1);
      check(status[6], 1'b0);
      for (n = 0; n < 10 && power_good !== 1'b1; n++) @(negedge ref_clk);
      check(power_good, 1'b1);
      // load above both current levels: limiting only, too few cycles for a trip
      oc_load = 11'h060;
      repeat (3) @(negedge ref_clk);
      check(pulse_limit, 1'b1);
      check(mon.oc_fault, 1'b1);
      check(mon.oc_warn, 1'b1);
      check(out_enable, 1'b1);
      oc_load = 11'h000;
      repeat (3) @(negedge ref_clk);
      check(pulse_limit, 1'b0);
      // between the two thresholds power good holds, below the lower one it drops
      vout = 16'h006F;
      repeat (5) @(negedge ref_clk);
      check(power_good, 1'b1);
      vout = 16'h0068;
      repeat (5) @(negedge ref_clk);
      check(power_good, 1'b0);
      // halving the loop scale halves the sense-pin thresholds
      scale_shift = 2'h1;
      repeat (3) @(negedge ref_clk);
      check(power_good, 1'b1);
      scale_shift = 2'h0;
      wr(`RFLC_CMD_UV_RSP, 16'h0080, 1'b0);
      vout = 16'h0050;
      repeat (5) @(negedge ref_clk);
      check(out_enable, 1'b0);
      check(status[6], 1'b1);
      // restart with the output held below the undervoltage limit trips the start-up timeout
      enable_pin = 1'b0;
      repeat (2) @(negedge ref_clk);
      wr(`RFLC_CMD_TON_MAX, 16'h0001, 1'b0);
      enable_pin = 1'b1;
      for (n = 0; n < 40 && mon.ton_max_fault !== 1'b1; n++) @(negedge ref_clk);
      check(mon.ton_max_fault, 1'b1);
      // a clear pulse drops the sticky busy bit
      clear_faults = 1'b1;
      @(negedge ref_clk);
      clear_faults = 1'b0;
      check(status[7], 1'b0);
      repeat (4) @(negedge ref_clk);
      print_verdict;
   end
endmodule // tb
`default_nettype wire
